// ### hdl/mic_defines.svh
// constants of the interrupt controller: register map, field positions, reset values
// assumes inclusion by mic_pkg, the controller module and its bench
//
// Operation
// R1: fifteen sources: six pin edges, eight peripheral events, one software break
// R2: maskable source fires only when request=1, enable=1 and mask flag=0
// R3: software writes set and clear every enable bit
// R4: software may clear a request bit; writing one never sets it
// R5: software break is never blocked; mask flag blocks all other sources
// R6: simultaneous requests are taken one at a time, highest priority first
// R7: on acceptance program counter then status word are pushed automatically
// R8: on acceptance mask flag is set and accepted request bit cleared
// R9: after stacking, vector entry of accepted source is loaded into program counter
// R10: changing an edge polarity may itself set that source's request bit
// R11: software disables, changes polarity, clears request, then re-enables
// R12: four pin polarities from edge register; two counter pins from timer mode register
// R13: each pin source requests on its selected rising or falling edge
// R14: reset acts as highest priority non-maskable source with its own vector
// R15: stacked status word carries break flag 1 when break caused the interrupt
// R16: a set request bit stays set until acceptance or software clear
`ifndef MIC_DEFINES_SVH
`define MIC_DEFINES_SVH

`define MIC_AW            8
`define MIC_OFS_REQ       8'h00
`define MIC_OFS_CLR       8'h04
`define MIC_OFS_EN        8'h08
`define MIC_OFS_EDGE      8'h0C
`define MIC_OFS_TMODE     8'h10
`define MIC_OFS_STAT      8'h14

`define MIC_RESP_OKAY     2'h0
`define MIC_RESP_SLVERR   2'h2

`define MIC_NREQ          14
`define MIC_NPIN          6
`define MIC_NEDGE         4
`define MIC_NCNTR         2
`define MIC_NPERIPH       8

`define MIC_REQ_RST       14'h0000
`define MIC_EN_RST        14'h0000
`define MIC_EDGE_RST      4'h0
`define MIC_TMODE_RST     2'h0

`define MIC_VEC_RESET_LO  16'hFFFC
`define MIC_SLOT_RESET    5'h00
`define MIC_SLOT_BRK      5'h10
`define MIC_PSW_BRK_BIT   4

`endif

// ### hdl/mic_pkg.sv
// types and the source-to-vector table of the interrupt controller
// assumes mic_defines.svh is on the include path
`include "mic_defines.svh"

package mic_pkg;

  typedef enum logic [2:0] {ST_RSTVEC, ST_IDLE, ST_PUSH_PCH, ST_PUSH_PCL, ST_PUSH_PSW, ST_VECTOR} mic_state_type;

  // request bit index to vector slot; slots 2 and 6 are unused, 5 is shared by pin 3 and serial 2
  localparam logic [4:0] MIC_SLOT_TABLE [`MIC_NREQ] = '{5'h01, 5'h03, 5'h04, 5'h05, 5'h05, 5'h07, 5'h08,
                                                      5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0E, 5'h0F};

  function automatic logic [15:0] mic_vector_type_addr(input logic [4:0] slot);
    mic_vector_type_addr = 16'(`MIC_VEC_RESET_LO - {10'h000, slot, 1'b0});
  endfunction

endpackage

// ### hdl/mic_interrupt_ctrl.sv
// interrupt controller: request/enable bits, edge detectors, priority pick, core stacking sequence
// assumes AXI4-Lite master on the register side and a core that pushes/loads on the strobes given
`timescale 1ns/100ps
`include "mic_defines.svh"

module mic_interrupt_ctrl
  import mic_pkg::*;
#(
  parameter int NREQ = `MIC_NREQ
)(
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     nrst,
  // AXI4-Lite slave
  input  wire logic [`MIC_AW-1:0]       s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  input  wire logic [`MIC_AW-1:0]       s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  // event sources
  input  wire logic [`MIC_NPIN-1:0]     extPin,
  input  wire logic [`MIC_NPERIPH-1:0]  periphEvt,
  input  wire logic                     softwareBreakInstruction,
  // processor core
  input  wire logic                     instrDone,
  input  wire logic                     maskFlag,
  input  wire logic [15:0]              pcIn,
  input  wire logic [7:0]               pswIn,
  output logic                          pushValid,
  output logic [7:0]                    pushData,
  output logic                          setMask,
  output logic                          vecLoad,
  output logic [15:0]                   vecAddr,
  // interrupt to system
  output logic                          irq
);

  logic                    rstMeta_r;
  logic                    rstN;
  mic_state_type           state_r;
  mic_state_type           state_nxt;
  logic [NREQ-1:0]         req_r;
  logic [NREQ-1:0]         en_r;
  logic [`MIC_NEDGE-1:0]   edgePolaritySelectReg_r;
  logic [`MIC_NCNTR-1:0]   timerPairModeReg_r;
  logic [`MIC_NPIN-1:0]    effPrev_r;
  logic                    edgeArmed_r;
  logic                    brkPend_r;
  logic                    brkCur_r;
  logic [4:0]              slot_r;
  logic [15:0]             pcHold_r;
  logic                    awready_r;
  logic                    arready_r;

  // reset release through two flops
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rstMeta_r <= 1'b0;
      rstN      <= 1'b0;
    end
    else
    begin
      rstMeta_r <= 1'b1;
      rstN      <= rstMeta_r;
    end
  end

  // pin edge detection; polarity 1 selects the falling edge
  wire [`MIC_NPIN-1:0] pinPol = {timerPairModeReg_r, edgePolaritySelectReg_r};  // R12
  wire [`MIC_NPIN-1:0] effLvl = extPin ^ pinPol;
  // a polarity flip inverts effLvl and can look like an edge, as intended
  // first sample after reset only primes the detector, so a pin resting at its active level is no edge
  wire [`MIC_NPIN-1:0] extHit = effLvl & ~effPrev_r & {`MIC_NPIN{edgeArmed_r}};  // R13 R10

  wire [NREQ-1:0] evtAll = {periphEvt[7], extHit[5:4], periphEvt[6:1], periphEvt[0], extHit[3:0]};  // R1

  // register bus decode
  wire wrFire = s_axi_awvalid & s_axi_wvalid & awready_r;
  wire rdFire = s_axi_arvalid & arready_r;
  wire [15:0] wrData = {s_axi_wstrb[1] ? s_axi_wdata[15:8] : 8'h00, s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00};
  wire [15:0] wrMask = {{8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
  wire wrClr   = wrFire & (s_axi_awaddr == `MIC_OFS_CLR);
  wire wrEn    = wrFire & (s_axi_awaddr == `MIC_OFS_EN);
  wire wrEdge  = wrFire & (s_axi_awaddr == `MIC_OFS_EDGE);
  wire wrTmode = wrFire & (s_axi_awaddr == `MIC_OFS_TMODE);
  wire wrHit   = wrClr | wrEn | wrEdge | wrTmode;
  wire rdHit   = (s_axi_araddr == `MIC_OFS_REQ) | (s_axi_araddr == `MIC_OFS_EN) | (s_axi_araddr == `MIC_OFS_EDGE)
               | (s_axi_araddr == `MIC_OFS_TMODE) | (s_axi_araddr == `MIC_OFS_STAT);
  wire [31:0] rdMux =
    (s_axi_araddr == `MIC_OFS_REQ)   ? {18'h00000, req_r} :
    (s_axi_araddr == `MIC_OFS_EN)    ? {18'h00000, en_r} :
    (s_axi_araddr == `MIC_OFS_EDGE)  ? {28'h0000000, edgePolaritySelectReg_r} :
    (s_axi_araddr == `MIC_OFS_TMODE) ? {30'h00000000, timerPairModeReg_r} :
    (s_axi_araddr == `MIC_OFS_STAT)  ? {24'h000000, brkPend_r, slot_r, state_r != ST_IDLE, 1'b0} : 32'h00000000;

  // priority pick: lowest index is highest priority
  wire [NREQ-1:0] pendMask = req_r & en_r;  // R2
  logic [3:0]      selIdx;
  logic [NREQ-1:0] selOneHot;
  always_comb
  begin
    selIdx    = 4'h0;
    selOneHot = '0;
    for (int i = NREQ - 1; i >= 0; i--)
    begin
      if (pendMask[i])
      begin
        selIdx    = 4'(i);  // R6
        selOneHot = NREQ'(1) << i;
      end
    end
  end
  // break ignores the mask flag and enables; maskable sources win on priority
  wire maskOk  = (|pendMask) & ~maskFlag;  // R2 R5
  wire accept  = (state_r == ST_IDLE) & instrDone & (maskOk | brkPend_r);  // R5
  wire selBrk  = ~maskOk;
  wire [NREQ-1:0] accClr = (accept & ~selBrk) ? selOneHot : '0;  // R8
  wire [NREQ-1:0] swClr  = wrClr ? wrData[NREQ-1:0] & wrMask[NREQ-1:0] : '0;  // R4
  wire [NREQ-1:0] clrAll = swClr | accClr;
  // a hardware event in the clearing cycle wins
  wire [NREQ-1:0] req_nxt = (req_r & ~clrAll) | evtAll;  // R16 R4

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      ST_RSTVEC:   state_nxt = ST_IDLE;
      ST_IDLE:     state_nxt = accept ? ST_PUSH_PCH : ST_IDLE;
      ST_PUSH_PCH: state_nxt = ST_PUSH_PCL;
      ST_PUSH_PCL: state_nxt = ST_PUSH_PSW;
      ST_PUSH_PSW: state_nxt = ST_VECTOR;
      ST_VECTOR:   state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      state_r   <= ST_RSTVEC;  // R14
      req_r     <= `MIC_REQ_RST;
      effPrev_r <= '0;
      edgeArmed_r <= 1'b0;
      brkPend_r <= 1'b0;
      brkCur_r  <= 1'b0;
      slot_r    <= `MIC_SLOT_RESET;
      pcHold_r  <= 16'h0000;
    end
    else
    begin
      state_r   <= state_nxt;
      req_r     <= req_nxt;
      effPrev_r <= effLvl;
      edgeArmed_r <= 1'b1;
      brkPend_r <= softwareBreakInstruction | (brkPend_r & ~(accept & selBrk));
      if (accept)
      begin
        brkCur_r <= selBrk;
        slot_r   <= selBrk ? `MIC_SLOT_BRK : MIC_SLOT_TABLE[selIdx];
        pcHold_r <= pcIn;
      end
    end
  end

  // software-visible control
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      en_r                    <= `MIC_EN_RST;
      edgePolaritySelectReg_r <= `MIC_EDGE_RST;
      timerPairModeReg_r      <= `MIC_TMODE_RST;
    end
    else
    begin
      if (wrEn)
        en_r <= (en_r & ~wrMask[NREQ-1:0]) | wrData[NREQ-1:0];  // R3
      if (wrEdge & s_axi_wstrb[0])
        edgePolaritySelectReg_r <= s_axi_wdata[`MIC_NEDGE-1:0];
      if (wrTmode & s_axi_wstrb[0])
        timerPairModeReg_r <= s_axi_wdata[`MIC_NCNTR-1:0];
    end
  end

  // core strobes: high byte, low byte, then status word, then vector
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      pushValid <= 1'b0;
      pushData  <= 8'h00;
      setMask   <= 1'b0;
      vecLoad   <= 1'b0;
      vecAddr   <= 16'h0000;
      irq       <= 1'b0;
    end
    else
    begin
      pushValid <= (state_r == ST_PUSH_PCH) | (state_r == ST_PUSH_PCL) | (state_r == ST_PUSH_PSW);  // R7
      unique case (state_r)
        ST_PUSH_PCH: pushData <= pcHold_r[15:8];
        ST_PUSH_PCL: pushData <= pcHold_r[7:0];
        ST_PUSH_PSW: pushData <= brkCur_r ? (pswIn | 8'(1 << `MIC_PSW_BRK_BIT)) : pswIn;  // R15
        default:     pushData <= pushData;
      endcase
      setMask <= (state_r == ST_VECTOR) | (state_r == ST_RSTVEC);  // R8
      vecLoad <= (state_r == ST_VECTOR) | (state_r == ST_RSTVEC);  // R9
      if (state_r == ST_VECTOR)
        vecAddr <= mic_vector_type_addr(slot_r);  // R9
      else if (state_r == ST_RSTVEC)
        vecAddr <= `MIC_VEC_RESET_LO;  // R14
      irq <= |pendMask;
    end
  end

  // AXI4-Lite: one write and one read at a time, ready raised one cycle after valid
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      awready_r     <= 1'b0;
      arready_r     <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `MIC_RESP_OKAY;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= `MIC_RESP_OKAY;
      s_axi_rdata   <= 32'h00000000;
    end
    else
    begin
      awready_r <= s_axi_awvalid & s_axi_wvalid & ~awready_r & ~s_axi_bvalid;
      arready_r <= s_axi_arvalid & ~arready_r & ~s_axi_rvalid;
      if (wrFire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wrHit ? `MIC_RESP_OKAY : `MIC_RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (rdFire)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rdMux;
        s_axi_rresp  <= rdHit ? `MIC_RESP_OKAY : `MIC_RESP_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready  = awready_r;
  assign s_axi_arready = arready_r;

  // checks
  a_mask_gate: assert property (@(posedge clk) disable iff (!rstN)  // R2
    (state_r == ST_IDLE) && instrDone && maskFlag && !brkPend_r |=> state_r == ST_IDLE)
    else $error("mask flag did not block a maskable request");

  a_brk_unmaskable: assert property (@(posedge clk) disable iff (!rstN)  // R5
    (state_r == ST_IDLE) && instrDone && brkPend_r |=> state_r == ST_PUSH_PCH)
    else $error("break request was not accepted");

  a_push_sequence: assert property (@(posedge clk) disable iff (!rstN)  // R7
    accept |=> ##1 pushValid[*3] ##1 (vecLoad && setMask && !pushValid))
    else $error("stacking sequence out of order");

  a_accept_clears: assert property (@(posedge clk) disable iff (!rstN)  // R8
    accept && !selBrk && !(|(selOneHot & evtAll)) |=> !(|(req_r & $past(selOneHot))))
    else $error("accepted request bit not cleared");

  a_req_sticky: assert property (@(posedge clk) disable iff (!rstN)  // R16
    ##1 ($past(req_r) & ~$past(clrAll) & ~req_r) == '0)
    else $error("request bit dropped without clear");

  a_only_hw_sets: assert property (@(posedge clk) disable iff (!rstN)  // R4
    ##1 (req_r & ~$past(req_r) & ~$past(evtAll)) == '0)
    else $error("request bit set without hardware event");

  a_edge_sets: assert property (@(posedge clk) disable iff (!rstN)  // R13
    |extHit |=> (req_r[3:0] & $past(extHit[3:0])) == $past(extHit[3:0]))
    else $error("pin edge did not set request");

  a_priority_pick: assert property (@(posedge clk) disable iff (!rstN)  // R6
    accept && !selBrk |-> selOneHot == (pendMask & (~pendMask + NREQ'(1))))
    else $error("lower priority source accepted first");

  a_vector_addr: assert property (@(posedge clk) disable iff (!rstN)  // R9
    accept && !selBrk |-> ##5 vecAddr == mic_vector_type_addr(MIC_SLOT_TABLE[$past(selIdx, 5)]))
    else $error("wrong vector entry loaded");

  a_brk_flag: assert property (@(posedge clk) disable iff (!rstN)  // R15
    accept |-> ##4 (pushData[`MIC_PSW_BRK_BIT] == ($past(selBrk, 4) | $past(pswIn[`MIC_PSW_BRK_BIT], 1))))
    else $error("stacked break flag wrong");

  a_reset_vector: assert property (@(posedge clk) disable iff (!rstN)  // R14
    state_r == ST_RSTVEC |=> vecLoad && vecAddr == `MIC_VEC_RESET_LO)
    else $error("reset vector not loaded");

  c_brk_taken:    cover property (@(posedge clk) disable iff (!rstN) accept && selBrk);
  c_mask_taken:   cover property (@(posedge clk) disable iff (!rstN) accept && !selBrk && maskFlag == 1'b0);
  c_polarity_hit: cover property (@(posedge clk) disable iff (!rstN) wrEdge ##1 (|extHit));
  c_two_pending:  cover property (@(posedge clk) disable iff (!rstN) accept && $countones(pendMask) > 1);

endmodule // mic_interrupt_ctrl

// ### tb/mic_core_model.sv
// core stand-in: supplies context, logs pushed bytes and vector loads
// assumes single-cycle strobes from the controller on the same clock
`timescale 1ns/100ps

module mic_core_model #(
  parameter logic [15:0] PC_VAL  = 16'h1000,
  parameter logic [7:0]  PSW_VAL = 8'h00
)(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // strobes from the controller
  input  wire logic        pushValid,
  input  wire logic [7:0]  pushData,
  input  wire logic        setMask,
  input  wire logic        vecLoad,
  input  wire logic [15:0] vecAddr,
  // bench control, acts like a mask-clear instruction
  input  wire logic        unmask,
  // core state
  output logic             instrDone,
  output logic             maskFlag,
  output logic [15:0]      pcIn,
  output logic [7:0]       pswIn,
  // observation
  output logic [23:0]      pushLog,
  output logic [15:0]      vecLog,
  output logic [7:0]       vecCount
);
  logic busy_r;

  assign instrDone = ~busy_r;
  assign pcIn      = PC_VAL;
  assign pswIn     = PSW_VAL;

  // no boundary from first push until the vector arrives, so nothing overlaps
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      busy_r   <= 1'b0;
      maskFlag <= 1'b1;
      pushLog  <= 24'h000000;
      vecLog   <= 16'h0000;
      vecCount <= 8'h00;
    end
    else
    begin
      if (pushValid) busy_r <= 1'b1;
      if (vecLoad) busy_r <= 1'b0;
      if (setMask) maskFlag <= 1'b1;
      else if (unmask) maskFlag <= 1'b0;
      if (pushValid) pushLog <= {pushLog[15:0], pushData};
      if (vecLoad) vecLog <= vecAddr;
      if (vecLoad) vecCount <= vecCount + 8'h01;
    end
  end
endmodule // mic_core_model

// ### tb/mic_interrupt_ctrl_tb_top.sv
// bench of the interrupt controller: AXI4-Lite tasks and sequenced tests
// assumes mic_pkg, the controller and mic_core_model are compiled first
`timescale 1ns/100ps
`include "mic_defines.svh"

module mic_interrupt_ctrl_tb_top;
  localparam logic [15:0] PC_VAL  = 16'hA5C3;
  localparam logic [7:0]  PSW_VAL = 8'h21;
  logic [7:0]  awAddr, arAddr, periphEvt, pswIn, pushData, vecCount;
  logic [31:0] wData, rData;
  logic [3:0]  wStrb;
  logic [1:0]  bResp, rResp;
  logic        clk, nrst, awValid, awReady, wValid, wReady, bValid, bReady, arValid, arReady, rValid, rReady;
  logic        software_break_instruction, unmask, irq, instrDone, maskFlag, pushValid, setMask, vecLoad;
  logic [5:0]  extPin;
  logic [15:0] pcIn, vecAddr, vecLog;
  logic [23:0] pushLog;
  int          errors, num_checks;

  mic_interrupt_ctrl dut (.clk(clk), .nrst(nrst), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
    .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
    .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
    .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady), .extPin(extPin),
    .periphEvt(periphEvt), .softwareBreakInstruction(software_break_instruction), .instrDone(instrDone), .maskFlag(maskFlag),
    .pcIn(pcIn), .pswIn(pswIn), .pushValid(pushValid), .pushData(pushData), .setMask(setMask),
    .vecLoad(vecLoad), .vecAddr(vecAddr), .irq(irq));

  mic_core_model #(.PC_VAL(PC_VAL), .PSW_VAL(PSW_VAL)) core (.clk(clk), .nrst(nrst),
    .pushValid(pushValid), .pushData(pushData), .setMask(setMask), .vecLoad(vecLoad), .vecAddr(vecAddr),
    .unmask(unmask), .instrDone(instrDone), .maskFlag(maskFlag), .pcIn(pcIn), .pswIn(pswIn),
    .pushLog(pushLog), .vecLog(vecLog), .vecCount(vecCount));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
      errors++;
    end
  endtask

  // bready and rready stay high, so the answer is taken at the edge it is seen
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    awAddr <= a;
    wData <= d;
    awValid <= 1'b1;
    wValid <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (awReady === 1'b1) awValid <= 1'b0;
      if (wReady === 1'b1) wValid <= 1'b0;
    end
    while (bValid !== 1'b1 && n < 100);
    chk($sformatf("write answer %h", a), 32'h1, {31'h0, bValid});
    chk($sformatf("write resp %h", a), {30'h0, er}, {30'h0, bResp});
  endtask

  task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    arAddr <= a;
    arValid <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
      if (arReady === 1'b1) arValid <= 1'b0;
    end
    while (rValid !== 1'b1 && n < 100);
    chk($sformatf("read answer %h", a), 32'h1, {31'h0, rValid});
    chk($sformatf("read data %h", a), ed, rData);
    chk($sformatf("read resp %h", a), {30'h0, er}, {30'h0, rResp});
  endtask

  task automatic waitVec(input logic [7:0] c);
    int n;
    n = 0;
    while (vecCount !== c && n < 50)
    begin
      @(posedge clk);
      n++;
    end
    chk("vector loads", {24'h0, c}, {24'h0, vecCount});
  endtask

  task automatic pulse(input logic [7:0] e, input logic b, input logic u);
    periphEvt <= e;
    software_break_instruction <= b;
    unmask <= u;
    @(posedge clk);
    periphEvt <= 8'h00;
    software_break_instruction <= 1'b0;
    unmask <= 1'b0;
    @(posedge clk);
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    final_report();
  end

  initial
  begin
    int pm [8];
    logic [7:0] ofs;
    int bp;
    pm = '{4, 5, 6, 7, 8, 9, 10, 13};
    {errors, num_checks} = '0;
    {nrst, awAddr, arAddr, wData, awValid, wValid, arValid, extPin, periphEvt, software_break_instruction, unmask} = '0;
    {wStrb, bReady, rReady} = 6'h3F;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    repeat (6) @(posedge clk);
    chk("reset vector", {16'h0, 16'hFFFC}, {16'h0, vecLog});
    chk("reset mask", 32'h1, {31'h0, maskFlag});
    axr(`MIC_OFS_REQ, 32'h0, `MIC_RESP_OKAY);
    axr(`MIC_OFS_STAT, 32'h0, `MIC_RESP_OKAY);
    axr(`MIC_OFS_EDGE, 32'h0, `MIC_RESP_OKAY);
    axr(`MIC_OFS_TMODE, 32'h0, `MIC_RESP_OKAY);
    axr(`MIC_OFS_CLR, 32'h0, `MIC_RESP_SLVERR);
    axr(8'h18, 32'h0, `MIC_RESP_SLVERR);
    axw(8'h18, 32'hFFFFFFFF, `MIC_RESP_SLVERR);
    axw(`MIC_OFS_EN, 32'h3FFF, `MIC_RESP_OKAY);
    axr(`MIC_OFS_EN, 32'h3FFF, `MIC_RESP_OKAY);
    axw(`MIC_OFS_EN, 32'h0, `MIC_RESP_OKAY);
    axr(`MIC_OFS_EN, 32'h0, `MIC_RESP_OKAY);
    $display("test registers done");
    pulse(8'h80, 1'b0, 1'b0);
    axw(`MIC_OFS_REQ, 32'h3FFF, `MIC_RESP_SLVERR);
    axr(`MIC_OFS_REQ, 32'h2000, `MIC_RESP_OKAY);
    chk("irq disabled", 32'h0, {31'h0, irq});
    axw(`MIC_OFS_EN, 32'h2000, `MIC_RESP_OKAY);
    repeat (3) @(posedge clk);
    chk("irq enabled", 32'h1, {31'h0, irq});
    chk("masked loads", 32'h1, {24'h0, vecCount});
    axw(`MIC_OFS_CLR, 32'h2000, `MIC_RESP_OKAY);
    axr(`MIC_OFS_REQ, 32'h0, `MIC_RESP_OKAY);
    axw(`MIC_OFS_EN, 32'h0, `MIC_RESP_OKAY);
    for (int k = 0; k < 8; k++)
    begin
      pulse(8'h01 << k, 1'b0, 1'b0);
      axr(`MIC_OFS_REQ, 32'h1 << pm[k], `MIC_RESP_OKAY);
      axw(`MIC_OFS_CLR, 32'h1 << pm[k], `MIC_RESP_OKAY);
    end
    $display("test request bits done");
    for (int i = 0; i < 6; i++)
    begin
      ofs = (i < 4) ? `MIC_OFS_EDGE : `MIC_OFS_TMODE;
      bp = (i < 4) ? i : i + 7;
      axw(ofs, 32'h1 << (i % 4), `MIC_RESP_OKAY);
      axr(`MIC_OFS_REQ, 32'h1 << bp, `MIC_RESP_OKAY);
      axw(ofs, 32'h0, `MIC_RESP_OKAY);
      axw(`MIC_OFS_CLR, 32'h1 << bp, `MIC_RESP_OKAY);
      axr(`MIC_OFS_REQ, 32'h0, `MIC_RESP_OKAY);
      extPin[i] <= 1'b1;
      repeat (3) @(posedge clk);
      axr(`MIC_OFS_REQ, 32'h1 << bp, `MIC_RESP_OKAY);
      axw(`MIC_OFS_CLR, 32'h1 << bp, `MIC_RESP_OKAY);
      extPin[i] <= 1'b0;
      repeat (3) @(posedge clk);
      axr(`MIC_OFS_REQ, 32'h0, `MIC_RESP_OKAY);
    end
    $display("test pin edges done");
    axw(`MIC_OFS_EN, 32'h00A0, `MIC_RESP_OKAY);
    pulse(8'h0A, 1'b0, 1'b0);
    repeat (10) @(posedge clk);
    chk("masked loads", 32'h1, {24'h0, vecCount});
    pulse(8'h00, 1'b0, 1'b1);
    waitVec(8'h02);
    chk("first vector", {16'h0, 16'hFFEE}, {16'h0, vecLog});
    chk("pushed context", {8'h0, PC_VAL, PSW_VAL}, {8'h0, pushLog});
    chk("mask after accept", 32'h1, {31'h0, maskFlag});
    axr(`MIC_OFS_REQ, 32'h0080, `MIC_RESP_OKAY);
    pulse(8'h00, 1'b0, 1'b1);
    waitVec(8'h03);
    chk("second vector", {16'h0, 16'hFFEA}, {16'h0, vecLog});
    $display("test acceptance done");
    pulse(8'h00, 1'b1, 1'b0);
    waitVec(8'h04);
    chk("break vector", {16'h0, 16'hFFDC}, {16'h0, vecLog});
    chk("break context", {8'h0, PC_VAL, PSW_VAL | 8'h10}, {8'h0, pushLog});
    axr(`MIC_OFS_STAT, 32'h40, `MIC_RESP_OKAY);
    $display("test break done");
    final_report();
  end
endmodule // mic_interrupt_ctrl_tb_top
